//--- audio_route_pkg.sv
/*
 Shared constants and carrier types for the audio routing block.
 Assumes one hclk domain; registers are reached over AHB-Lite.
*/
package audio_route_pkg;
  localparam int SAMPLE_W = 24;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } sample_t;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CLKSEL = 6'h08;
  localparam logic [5:0] IDX_PCFG3 = 6'h0c;
  localparam logic [5:0] IDX_PCFG4 = 6'h0d;
  localparam logic [5:0] IDX_SCFG2 = 6'h0e;
  localparam logic [5:0] IDX_DACCTL = 6'h0f;
  localparam logic [5:0] IDX_SPDTX = 6'h1e;
  localparam logic [5:0] IDX_STATUS = 6'h20;

  // Field positions
  localparam int SRC_LSB = 7;
  localparam int SPDIF_OUT_SOURCE_SEL_LSB = 0;
  localparam int THROUGH_BIT = 3;
  localparam int MODE_BIT = 8;
  localparam int DACCLK_LSB = 0;
  localparam int STEER1_LSB = 0;
  localparam int STEER2_LSB = 2;
  localparam int STEER3_LSB = 4;

  // Reset values
  localparam logic [8:0] RST_CLKSEL = 9'h000;
  localparam logic [8:0] RST_PCFG3 = 9'h1a4;
  localparam logic [8:0] RST_PCFG4 = 9'h080;
  localparam logic [8:0] RST_SCFG2 = 9'h000;
  localparam logic [8:0] RST_DACCTL = 9'h000;
  localparam logic [8:0] RST_SPDTX = 9'h000;

  // Source select codes
  localparam logic [1:0] SRC_SPDIF = 2'h0;
  localparam logic [1:0] SRC_ADC = 2'h1;
  localparam logic [1:0] SRC_SEC = 2'h2;
  localparam logic [1:0] SRC_PRI = 2'h3;

  typedef enum logic [1:0] {
    CLK_MCLK = 2'b00,
    CLK_PLLA = 2'b01,
    CLK_PLLB = 2'b10
  } dac_clk_t;

  typedef enum logic [2:0] {
    RATE_128 = 3'b000,
    RATE_192 = 3'b001,
    RATE_256 = 3'b010,
    RATE_384 = 3'b011,
    RATE_512 = 3'b100,
    RATE_768 = 3'b101,
    RATE_1152 = 3'b110
  } dac_rate_t;

  // Midpoints between adjacent ratios, in master clock edges
  localparam logic [10:0] THR_192 = 11'h0a0;
  localparam logic [10:0] THR_256 = 11'h0e0;
  localparam logic [10:0] THR_384 = 11'h140;
  localparam logic [10:0] THR_512 = 11'h1c0;
  localparam logic [10:0] THR_768 = 11'h280;
  localparam logic [10:0] THR_1152 = 11'h3c0;
  localparam logic [10:0] CNT_MAX = 11'h7ff;
endpackage : audio_route_pkg

//--- audio_route.sv
/*
 Audio data routing, DAC clock select and DAC rate detection, with a
 sample FIFO in the DAC1 path and an AHB-Lite register slave.
 Assumes sample streams come from logic on hclk; clock and frame pins
 are asynchronous and are sampled, so they must run below hclk/2.
*/
// Local design decision: the AHB-Lite register port.
// Summary of operation
// - DAC1 source field bits 8:7: 00 S/PDIF, 10 secondary, 11 primary.
// - DAC2 and DAC3 take only primary port receiver data.
// - Any of the three data input pins can be steered to any DAC.
// - The pin steered to DAC1 also feeds S/PDIF and secondary transmitters.
// - Primary transmitter source: 00 S/PDIF, 01 ADC, 10 secondary; reset 01.
// - Secondary transmitter source: 00 S/PDIF, 01 ADC, 11 primary; reset 00.
// - S/PDIF transmitter source: 00 S/PDIF, 01 ADC, 10 secondary, 11 primary.
// - Through bit 3 drives output pin from S/PDIF input mux when set.
// - DAC clock: 00 and 11 master pin, 01 PLL A, 10 PLL B.
// - DAC1 from S/PDIF forces PLL A clock and, with mode bit clear, powers down DAC2/3.
// - Mode bit 8 picks subframe or primary frame clock, DAC2/3 power.
// - Rate logic picks 128 to 1152 times sample rate from master clock.
// - Primary port data uses the primary receive frame clock for rate.
// - Secondary port data uses the secondary frame clock for rate.
// - S/PDIF data without mode uses the recovered subframe clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module sample_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = (s_r.cnt != CW'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : sample_fifo

////////////////////////////////////////////////////////////////////////
module audio_route import audio_route_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire sample_t [2:0] dac_data_input_pins,
  input wire sample_t spdif_rx_data,
  input wire sample_t secondary_rx_data,
  input wire sample_t adc_data,
  output logic dac1_fill_ready,
  output sample_t dac1_data,
  input wire logic dac1_ready,
  output sample_t dac2_data,
  output sample_t dac3_data,
  output sample_t primary_tx_data,
  output sample_t secondary_tx_data,
  output sample_t spdif_tx_data,
  input wire logic mclk_pin,
  input wire logic pll_a_clock,
  input wire logic pll_b_clock,
  input wire logic primary_rx_frame_clock,
  input wire logic secondary_port_frame_clock,
  input wire logic spdif_subframe_clock,
  input wire logic spdif_in_mux_bit,
  input wire logic spdif_tx_bit,
  output logic spdif_output_pin,
  output logic [1:0] dac_clk_sel,
  output logic dac23_power_down,
  output logic [2:0] dac_rate
);
  // Pin bit positions in the synchroniser vectors
  localparam int P_MCLK = 0;
  localparam int P_PLLA = 1;
  localparam int P_PLLB = 2;
  localparam int P_PRI = 3;
  localparam int P_SEC = 4;
  localparam int P_SUB = 5;
  localparam int P_SPIN = 6;
  localparam int P_STX = 7;

  typedef struct packed {
    logic [8:0] clksel;
    logic [8:0] pcfg3;
    logic [8:0] pcfg4;
    logic [8:0] scfg2;
    logic [8:0] dacctl;
    logic [8:0] spdtx;
    logic wr_pend;
    logic [5:0] wr_idx;
    logic [31:0] rdata;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [10:0] cnt;
    logic [2:0] rate;
    sample_t dac2;
    sample_t dac3;
    sample_t ptx;
    sample_t stx;
    sample_t sptx;
    logic pin;
  } route_state_t;

  route_state_t s_r;
  route_state_t s_nxt;
  sample_t [2:0] steer;
  sample_t dac1_in;
  logic [1:0] dac1_src;
  logic rx2dac;
  logic pd23;
  dac_clk_t eff_clk;
  logic m_edge;
  logic f_edge;
  logic [7:0] pins;
  logic fifo_valid;
  logic [SAMPLE_W-1:0] fifo_data;

  function automatic sample_t src_mux(input logic [1:0] sel,
      input sample_t a0, input sample_t a1, input sample_t a2,
      input sample_t a3);
    case (sel)
      2'h0: src_mux = a0;
      2'h1: src_mux = a1;
      2'h2: src_mux = a2;
      default: src_mux = a3;
    endcase
  endfunction : src_mux

  function automatic logic [2:0] rate_of(input logic [10:0] n);
    if (n < THR_192) rate_of = RATE_128;
    else if (n < THR_256) rate_of = RATE_192;
    else if (n < THR_384) rate_of = RATE_256;
    else if (n < THR_512) rate_of = RATE_384;
    else if (n < THR_768) rate_of = RATE_512;
    else if (n < THR_1152) rate_of = RATE_768;
    else rate_of = RATE_1152;
  endfunction : rate_of

  assign pins = {spdif_tx_bit, spdif_in_mux_bit, spdif_subframe_clock,
    secondary_port_frame_clock, primary_rx_frame_clock, pll_b_clock,
    pll_a_clock, mclk_pin};

  ////////////////////////////////////////////////////////////////////
  // Data routing

  // Pin code 3 has no pin behind it and carries nothing
  for (genvar k = 0; k < 3; k++) begin : g_steer
    logic [1:0] psel;
    assign psel = s_r.pcfg3[2*k+1:2*k];
    assign steer[k] = (psel == 2'h3) ? '0 : dac_data_input_pins[psel];
  end

  assign dac1_src = s_r.pcfg3[SRC_LSB+1:SRC_LSB];
  assign rx2dac = s_r.dacctl[MODE_BIT];
  assign pd23 = (dac1_src == SRC_SPDIF) && !rx2dac;

  // Code 01 is reserved for DAC1 and yields no samples
  assign dac1_in = src_mux(dac1_src, spdif_rx_data, '0,
    secondary_rx_data, steer[0]);

  sample_fifo #(
    .W(SAMPLE_W),
    .DEPTH(DEPTH)
  ) u_dac1_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(dac1_in.valid),
    .in_data(dac1_in.data),
    .in_ready(dac1_fill_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(dac1_ready)
  );
  assign dac1_data = {fifo_valid, fifo_data};

  ////////////////////////////////////////////////////////////////////
  // Clock and rate source

  always_comb begin
    if (dac1_src == SRC_SPDIF) begin
      eff_clk = CLK_PLLA;
    end else begin
      case (s_r.clksel[DACCLK_LSB+1:DACCLK_LSB])
        2'h1: eff_clk = CLK_PLLA;
        2'h2: eff_clk = CLK_PLLB;
        default: eff_clk = CLK_MCLK;
      endcase
    end
  end

  always_comb begin
    case (eff_clk)
      CLK_PLLA: m_edge = s_r.sync2[P_PLLA] && !s_r.prev[P_PLLA];
      CLK_PLLB: m_edge = s_r.sync2[P_PLLB] && !s_r.prev[P_PLLB];
      default: m_edge = s_r.sync2[P_MCLK] && !s_r.prev[P_MCLK];
    endcase
    case (dac1_src)
      SRC_PRI: f_edge = s_r.sync2[P_PRI] && !s_r.prev[P_PRI];
      SRC_SEC: f_edge = s_r.sync2[P_SEC] && !s_r.prev[P_SEC];
      SRC_SPDIF: begin
        if (rx2dac) begin
          f_edge = s_r.sync2[P_PRI] && !s_r.prev[P_PRI];
        end else begin
          f_edge = s_r.sync2[P_SUB] && !s_r.prev[P_SUB];
        end
      end
      default: f_edge = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State update: registers, synchronisers, outputs

  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = pins;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;

    if (s_r.wr_pend) begin
      case (s_r.wr_idx)
        IDX_CLKSEL: s_nxt.clksel = hwdata[8:0];
        IDX_PCFG3: s_nxt.pcfg3 = hwdata[8:0];
        IDX_PCFG4: s_nxt.pcfg4 = hwdata[8:0];
        IDX_SCFG2: s_nxt.scfg2 = hwdata[8:0];
        IDX_DACCTL: s_nxt.dacctl = hwdata[8:0];
        IDX_SPDTX: s_nxt.spdtx = hwdata[8:0];
        default: s_nxt.wr_pend = 1'b0;
      endcase
    end
    s_nxt.wr_pend = 1'b0;
    // Reads see a write still in its data phase
    if (hsel && hready && htrans[1]) begin
      s_nxt.wr_pend = hwrite;
      s_nxt.wr_idx = haddr[7:2];
      if (!hwrite) begin
        case (haddr[7:2])
          IDX_CLKSEL: s_nxt.rdata = {23'h0, s_nxt.clksel};
          IDX_PCFG3: s_nxt.rdata = {23'h0, s_nxt.pcfg3};
          IDX_PCFG4: s_nxt.rdata = {23'h0, s_nxt.pcfg4};
          IDX_SCFG2: s_nxt.rdata = {23'h0, s_nxt.scfg2};
          IDX_DACCTL: s_nxt.rdata = {23'h0, s_nxt.dacctl};
          IDX_SPDTX: s_nxt.rdata = {23'h0, s_nxt.spdtx};
          IDX_STATUS: s_nxt.rdata = {26'h0, pd23, eff_clk, s_r.rate};
          default: s_nxt.rdata = 32'h0;
        endcase
      end
    end

    // Master edges per frame period give the ratio
    if (f_edge) begin
      s_nxt.rate = rate_of(s_r.cnt);
      s_nxt.cnt = 11'h0;
    end else if (m_edge && s_r.cnt != CNT_MAX) begin
      s_nxt.cnt = s_r.cnt + 11'h1;
    end

    s_nxt.dac2 = pd23 ? '0 : steer[1];
    s_nxt.dac3 = pd23 ? '0 : steer[2];
    s_nxt.ptx = src_mux(s_r.pcfg4[SRC_LSB+1:SRC_LSB], spdif_rx_data,
      adc_data, secondary_rx_data, '0);
    s_nxt.stx = src_mux(s_r.scfg2[SRC_LSB+1:SRC_LSB], spdif_rx_data,
      adc_data, '0, steer[0]);
    s_nxt.sptx = src_mux(s_r.spdtx[SPDIF_OUT_SOURCE_SEL_LSB+1:SPDIF_OUT_SOURCE_SEL_LSB], spdif_rx_data,
      adc_data, secondary_rx_data, steer[0]);
    s_nxt.pin = s_r.spdtx[THROUGH_BIT] ? s_r.sync2[P_SPIN]
      : s_r.sync2[P_STX];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.clksel <= RST_CLKSEL;
      s_r.pcfg3 <= RST_PCFG3;
      s_r.pcfg4 <= RST_PCFG4;
      s_r.scfg2 <= RST_SCFG2;
      s_r.dacctl <= RST_DACCTL;
      s_r.spdtx <= RST_SPDTX;
      s_r.rate <= RATE_256;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign dac2_data = s_r.dac2;
  assign dac3_data = s_r.dac3;
  assign primary_tx_data = s_r.ptx;
  assign secondary_tx_data = s_r.stx;
  assign spdif_tx_data = s_r.sptx;
  assign spdif_output_pin = s_r.pin;
  assign dac_clk_sel = eff_clk;
  assign dac23_power_down = pd23;
  assign dac_rate = s_r.rate;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_dac1_route: assert property (
    dac1_src == SRC_SEC |-> dac1_in == secondary_rx_data)
    else $error("dac1 not fed from secondary port");
  a_dac23_primary: assert property (
    !pd23 |=> dac2_data == $past(steer[1]) && dac3_data == $past(steer[2]))
    else $error("dac2/3 not fed from steered pins");
  a_stx_follows: assert property (
    s_r.scfg2[8:7] == SRC_PRI |=> secondary_tx_data == $past(steer[0]))
    else $error("secondary tx not following dac1 pin");
  a_ptx_reserved: assert property (
    s_r.pcfg4[8:7] == 2'h3 |=> !primary_tx_data.valid)
    else $error("reserved primary tx code carried data");
  a_sptx_adc: assert property (
    s_r.spdtx[1:0] == SRC_ADC |=> spdif_tx_data == $past(adc_data))
    else $error("spdif tx not fed from adc");
  a_through_pin: assert property (
    s_r.spdtx[THROUGH_BIT] |=> spdif_output_pin == $past(pins[P_SPIN], 3))
    else $error("through pin does not follow input mux");
  a_clk_forced: assert property (
    dac1_src == SRC_SPDIF |-> dac_clk_sel == CLK_PLLA)
    else $error("pll a not forced for spdif dac1");
  a_clk_decode: assert property (
    dac1_src != SRC_SPDIF && s_r.clksel[1:0] == 2'h3
      |-> dac_clk_sel == CLK_MCLK)
    else $error("clock code 11 not master pin");
  a_pd_mode: assert property (
    dac1_src == SRC_SPDIF && !rx2dac
      |-> dac23_power_down ##1 !dac2_data.valid)
    else $error("dac2/3 not powered down");
  a_rate_latch: assert property (
    f_edge && s_r.cnt >= THR_1152 |=> dac_rate == RATE_1152)
    else $error("rate not latched on frame edge");
endmodule : audio_route

//--- audio_source_model.sv
/*
 Far-side model: input pin, S/PDIF rx, secondary rx and ADC streams,
 plus master and frame clocks. Assumes the routing block runs on hclk.
*/
`timescale 1ns/1ps

module audio_source_model import audio_route_pkg::*; #(
  parameter int PRI = 128,
  parameter int SEC = 384,
  parameter int SUB = 768
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pause,
  input wire logic fill_ready,
  output sample_t [2:0] pins,
  output sample_t spdif,
  output sample_t sec,
  output sample_t adc,
  output logic mclk,
  output logic pri_frame,
  output logic sec_frame,
  output logic sub_frame
);
  logic [31:0] t;
  logic [19:0] cnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t <= '0;
      cnt <= '0;
    end else begin
      t <= t + 32'h1;
      // Stream holds while the buffer refuses
      if (!pause && fill_ready) begin
        cnt <= cnt + 20'h1;
      end
    end
  end

  // Paused lines show garbage, not the last sample
  // Stream state passed in so each assign re-evaluates as it moves
  function automatic sample_t mk(input logic [3:0] tag, input logic p,
      input logic [19:0] c);
    return {!p, p ? ~{tag, c} : {tag, c}};
  endfunction : mk

  ////////////////////////////////////////////////////////////////////
  // One counter for every clock keeps S/PDIF locked to the frames
  assign mclk = t[2];
  assign pri_frame = (t % (PRI * 8)) < PRI * 4;
  assign sec_frame = (t % (SEC * 8)) < SEC * 4;
  assign sub_frame = (t % (SUB * 8)) < SUB * 4;
  assign pins[0] = mk(4'h1, pause, cnt);
  assign pins[1] = mk(4'h2, pause, cnt);
  assign pins[2] = mk(4'h3, pause, cnt);
  assign spdif = mk(4'h4, pause, cnt);
  assign sec = mk(4'h5, pause, cnt);
  assign adc = mk(4'h6, pause, cnt);
endmodule : audio_source_model

//--- tb_top.sv
/*
 Testbench for audio_route: AHB-Lite register tasks, routing, clock
 select, rate detection and DAC1 buffer tests. Assumes the source model.
*/
`timescale 1ns/1ps

module tb_top import audio_route_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pause;
  logic dac1_ready, in_bit, tx_bit, fill_ready, mclk, pfr, sfr, subfr;
  logic spdif_output_pin, dac23_power_down;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, dac_clk_sel;
  logic [2:0] hsize, dac_rate;
  logic [23:0] prev;
  sample_t [2:0] pins;
  sample_t spdif, sec, adc, dac1_data, dac2_data, dac3_data;
  sample_t ptx, stx, sptx;
  int n_mismatch, checks, cyc, k, n;
  logic [31:0] ra [6] = '{32'h20, 32'h30, 32'h34, 32'h38, 32'h3c, 32'h78};
  logic [31:0] rv [6] = '{32'h0, 32'h1a4, 32'h80, 32'h0, 32'h0, 32'h0};
  logic [31:0] ce [4] = '{32'h0, 32'h1, 32'h2, 32'h0};
  logic [31:0] pe [4] = '{32'h14, 32'h16, 32'h15, 32'h0};
  logic [31:0] se [4] = '{32'h14, 32'h16, 32'h0, 32'h11};
  logic [31:0] xe [4] = '{32'h14, 32'h16, 32'h15, 32'h11};
  logic [31:0] dc [3] = '{32'h9, 32'h109, 32'h189};
  logic [31:0] de [3] = '{32'h14, 32'h15, 32'h12};

  audio_route audio_route_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .dac_data_input_pins(pins), .spdif_rx_data(spdif),
    .secondary_rx_data(sec), .adc_data(adc), .dac1_fill_ready(fill_ready),
    .dac1_data(dac1_data), .dac1_ready(dac1_ready), .dac2_data(dac2_data),
    .dac3_data(dac3_data), .primary_tx_data(ptx), .secondary_tx_data(stx),
    .spdif_tx_data(sptx), .mclk_pin(mclk), .pll_a_clock(mclk),
    .pll_b_clock(mclk), .primary_rx_frame_clock(pfr),
    .secondary_port_frame_clock(sfr), .spdif_subframe_clock(subfr),
    .spdif_in_mux_bit(in_bit), .spdif_tx_bit(tx_bit),
    .spdif_output_pin(spdif_output_pin), .dac_clk_sel(dac_clk_sel),
    .dac23_power_down(dac23_power_down), .dac_rate(dac_rate)
  );

  audio_source_model audio_source_model_inst (
    .hclk(hclk), .hresetn(hresetn), .pause(pause),
    .fill_ready(fill_ready), .pins(pins), .spdif(spdif), .sec(sec),
    .adc(adc), .mclk(mclk), .pri_frame(pfr), .sec_frame(sfr),
    .sub_frame(subfr)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] tg(input sample_t s);
    return {27'h0, s.valid, s.data[23:20]};
  endfunction : tg

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdchk

  // Write, register stage and pin synchroniser all land within this
  task automatic st;
    repeat (6) @(posedge hclk);
    #1;
  endtask : st

  task automatic wait_rate(input logic [2:0] e);
    for (k = 0; k < 20000 && dac_rate !== e; k++) begin
      @(posedge hclk);
    end
    check({29'h0, dac_rate}, {29'h0, e});
  endtask : wait_rate

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 70000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, pause} = '0;
    hsize = 3'h2;
    dac1_ready = 1'b1;
    in_bit = 1'b1;
    tx_bit = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(ra[i], rv[i]);
    xfer(1'b1, 32'h20, 32'hffffffff);
    rdchk(32'h20, 32'h1ff);
    xfer(1'b1, 32'h44, 32'h1ff);
    rdchk(32'h44, 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 32'h20, 32'(i));
      st;
      check({30'h0, dac_clk_sel}, ce[i]);
    end
    check(tg(dac2_data), 32'h12);
    check(tg(dac3_data), 32'h13);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 32'h34, 32'(i) << 7);
      xfer(1'b1, 32'h38, 32'(i) << 7);
      xfer(1'b1, 32'h78, 32'(i));
      st;
      check(tg(ptx), pe[i]);
      check(tg(stx), se[i]);
      check(tg(sptx), xe[i]);
    end
    xfer(1'b1, 32'h30, 32'h189);
    st;
    check(tg(dac2_data), 32'h13);
    check(tg(dac3_data), 32'h11);
    check(tg(stx), 32'h12);
    check(tg(sptx), 32'h12);
    check({31'h0, spdif_output_pin}, 32'h0);
    xfer(1'b1, 32'h78, 32'h8);
    st;
    check({31'h0, spdif_output_pin}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 32'h30, dc[i]);
      st;
      check(tg(dac1_data), de[i]);
    end
    wait_rate(RATE_128);
    xfer(1'b1, 32'h30, 32'h109);
    wait_rate(RATE_384);
    xfer(1'b1, 32'h30, 32'h9);
    st;
    check({30'h0, dac_clk_sel}, {30'h0, CLK_PLLA});
    check({31'h0, dac23_power_down}, 32'h1);
    wait_rate(RATE_768);
    rdchk(32'h80, 32'h2d);
    xfer(1'b1, 32'h3c, 32'h100);
    st;
    check({31'h0, dac23_power_down}, 32'h0);
    check(tg(dac2_data), 32'h13);
    wait_rate(RATE_128);
    // Reserved DAC1 code has no frame clock, so the count climbs past THR_1152
    xfer(1'b1, 32'h30, 32'h089);
    repeat (8200) @(posedge hclk);
    #1;
    check({31'h0, dac1_data.valid}, 32'h0);
    xfer(1'b1, 32'h30, 32'h189);
    wait_rate(RATE_1152);
    // Flush, then fill with the sink stalled until the buffer refuses
    pause <= 1'b1;
    repeat (40) @(posedge hclk);
    dac1_ready <= 1'b0;
    pause <= 1'b0;
    for (k = 0; k < 200 && fill_ready !== 1'b0; k++) begin
      @(posedge hclk);
      #1;
    end
    pause <= 1'b1;
    check({31'h0, fill_ready}, 32'h0);
    n = 1;
    prev = dac1_data.data;
    @(posedge hclk);
    dac1_ready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge hclk);
      #1;
      if (dac1_data.valid !== 1'b1) break;
      check({8'h0, dac1_data.data}, {8'h0, prev + 24'h1});
      prev = dac1_data.data;
      n++;
    end
    check(32'(n), 32'(FIFO_DEPTH));
    tally_and_finish;
  end
endmodule : tb_top
